// ### hdl/ssp_defines.vh
/*
  Constants for the serial unit: sampling counts, frame figures and
  reset values. Included by the serial unit design file only.
*/
`ifndef SSP_DEFINES_VH
`define SSP_DEFINES_VH

// ----------------------------------------------------------------
// sampling in asynchronous mode
// ----------------------------------------------------------------
// bit rate is one sixteenth of the sampling clock
`define SSP_OVERSAMPLE      16
`define SSP_SUB_LAST        4'hF
`define SSP_SUB_MID         4'h7
// external clock at most a quarter of the system clock
`define SSP_EXT_CLK_RATIO   4

// ----------------------------------------------------------------
// frame figures
// ----------------------------------------------------------------
`define SSP_BIT_LAST_8      3'h7
`define SSP_BIT_LAST_7      3'h6
`define SSP_SYNC_BIT_LAST   3'h7
`define SSP_MARK            1'b1
`define SSP_SPACE           1'b0
`define SSP_SCK_IDLE        1'b1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SSP_RST_BYTE        8'h00
`define SSP_RST_SUB         4'h0
`define SSP_RST_BITS        3'h0
`define SSP_RST_SYNC3       3'h7

`endif

// ### hdl/ssp_serial_unit.v
/*
  Serial unit with asynchronous and clocked synchronous modes,
  double-buffered transmit and receive paths and a parity error flag.
  Assumes control bits are held steady while a transfer runs, and that
  an external clock on the serial clock pin is at most a quarter of clk.
*/
// Overview of operation
// - parity error sets the parity error flag
// - bad-parity byte buffered, full flag stays clear
// - flag set blocks reception, synchronous transmission
// - flag cleared by read as one, write zero
// - receive disable leaves parity flag alone
// - external clock divided by sixteen per bit in async mode
// - start low, data, parity, high stops
// - idle line rests at mark level
// - mark-to-space edge starts a reception
// - transmitter and receiver run independently
// - both paths double buffered
// - twelve asynchronous frame formats selectable
// - synchronous character is eight bits, unframed
// - synchronous data changes on falling edge
// - synchronous data sampled on rising edge
// - line keeps last bit after character
// - no parity or multiprocessor bit synchronous
// - clock source select picks internal or pin
// - internal synchronous clock driven on pin
// - eight clock pulses per character
// - serial clock high while idle
// - synchronous duplex shares one serial clock
`timescale 1ns/100ps
`include "ssp_defines.vh"

module ssp_serial_unit (
  // clock and reset
  input  wire       clk,
  input  wire       resetn,
  // format and clock control
  input  wire       mode_sync,
  input  wire       data_seven,
  input  wire       parity_en,
  input  wire       parity_odd,
  input  wire       stop_two,
  input  wire       clock_source_select_hi,
  input  wire       clock_source_select_lo,
  input  wire [7:0] baud_div,
  input  wire       tx_enable,
  input  wire       rx_enable,
  // transmit buffer
  input  wire [7:0] tx_data,
  input  wire       tx_write,
  output reg        tx_empty_reg,
  // receive buffer and status
  input  wire       rx_read,
  output reg  [7:0] rx_buffer_reg,
  output reg        rx_full_flag_reg,
  input  wire       per_read,
  input  wire       per_write_zero,
  output reg        per_flag_reg,
  // serial pins
  input  wire       rxd_in,
  output reg        txd_out_reg,
  input  wire       sck_in,
  output reg        sck_out_reg,
  output reg        sck_oe_n_reg
);

  localparam ATX_IDLE  = 3'h0;
  localparam ATX_START = 3'h1;
  localparam ATX_DATA  = 3'h2;
  localparam ATX_PAR   = 3'h3;
  localparam ATX_STOP  = 3'h4;

  localparam ARX_IDLE  = 3'h0;
  localparam ARX_START = 3'h1;
  localparam ARX_DATA  = 3'h2;
  localparam ARX_PAR   = 3'h3;
  localparam ARX_STOP  = 3'h4;

  localparam SY_IDLE   = 1'b0;
  localparam SY_RUN    = 1'b1;

  // ----------------------------------------------------------------
  // pin synchronisers and clock selection
  // ----------------------------------------------------------------
  reg  [2:0] rxd_sync_reg;
  reg  [2:0] sck_sync_reg;
  reg        rxd_f_reg;
  reg        rxd_prev_reg;
  reg        sck_f_reg;
  reg        sck_prev_reg;
  reg  [7:0] div_cnt_reg;
  reg        brg_tick_reg;
  // shared by both engines, so declared ahead of them
  reg  [7:0] tx_data_buf_reg;

  // a level counts only once the second and third stages agree
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rxd_sync_reg <= `SSP_RST_SYNC3;
      sck_sync_reg <= `SSP_RST_SYNC3;
      rxd_f_reg    <= `SSP_MARK;
      rxd_prev_reg <= `SSP_MARK;
      sck_f_reg    <= `SSP_SCK_IDLE;
      sck_prev_reg <= `SSP_SCK_IDLE;
    end else begin
      rxd_sync_reg <= {rxd_sync_reg[1:0], rxd_in};
      sck_sync_reg <= {sck_sync_reg[1:0], sck_in};
      if (rxd_sync_reg[1] == rxd_sync_reg[2])
        rxd_f_reg <= rxd_sync_reg[2];
      if (sck_sync_reg[1] == sck_sync_reg[2])
        sck_f_reg <= sck_sync_reg[2];
      rxd_prev_reg <= rxd_f_reg;
      sck_prev_reg <= sck_f_reg;
    end
  end

  // baud generator: one tick every baud_div+1 cycles
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_cnt_reg  <= `SSP_RST_BYTE;
      brg_tick_reg <= 1'b0;
    end else if (div_cnt_reg == baud_div) begin
      div_cnt_reg  <= `SSP_RST_BYTE;
      brg_tick_reg <= 1'b1;
    end else begin
      div_cnt_reg  <= div_cnt_reg + 8'h01;
      brg_tick_reg <= 1'b0;
    end
  end

  wire ext_clk   = clock_source_select_hi;
  wire ext_rise  = sck_f_reg & ~sck_prev_reg;
  wire ext_fall  = ~sck_f_reg & sck_prev_reg;
  // external clock in async mode is the sixteen-times clock
  wire tick16    = ext_clk ? ext_rise : brg_tick_reg;
  wire [2:0] last_bit = data_seven ? `SSP_BIT_LAST_7 : `SSP_BIT_LAST_8;

  // ----------------------------------------------------------------
  // asynchronous transmitter
  // ----------------------------------------------------------------
  reg  [2:0] atx_state_reg;
  reg  [3:0] atx_sub_reg;
  reg  [2:0] atx_bit_reg;
  reg  [7:0] atx_sh_reg;
  reg        atx_par_reg;
  reg        atx_stop2_reg;
  reg        atx_line_reg;

  wire atx_take = ~mode_sync & tx_enable & ~tx_empty_reg & (atx_state_reg == ATX_IDLE);
  wire atx_end  = tick16 & (atx_sub_reg == `SSP_SUB_LAST);

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      atx_state_reg <= ATX_IDLE;
      atx_sub_reg   <= `SSP_RST_SUB;
      atx_bit_reg   <= `SSP_RST_BITS;
      atx_sh_reg    <= `SSP_RST_BYTE;
      atx_par_reg   <= 1'b0;
      atx_stop2_reg <= 1'b0;
      atx_line_reg  <= `SSP_MARK;
    end else begin
      if (tick16)
        atx_sub_reg <= atx_sub_reg + 4'h1;
      case (atx_state_reg)
        ATX_IDLE: begin
          atx_line_reg <= `SSP_MARK;
          if (atx_take) begin
            atx_sh_reg    <= tx_data_buf_reg;
            atx_par_reg   <= parity_odd;
            atx_state_reg <= ATX_START;
            atx_sub_reg   <= `SSP_RST_SUB;
            atx_line_reg  <= `SSP_SPACE;
          end
        end
        ATX_START: begin
          if (atx_end) begin
            atx_state_reg <= ATX_DATA;
            atx_bit_reg   <= `SSP_RST_BITS;
            atx_line_reg  <= atx_sh_reg[0];
            atx_par_reg   <= atx_par_reg ^ atx_sh_reg[0];
            atx_sh_reg    <= {1'b0, atx_sh_reg[7:1]};
          end
        end
        ATX_DATA: begin
          if (atx_end) begin
            atx_bit_reg <= atx_bit_reg + 3'h1;
            if (atx_bit_reg == last_bit) begin
              atx_stop2_reg <= stop_two;
              if (parity_en) begin
                atx_state_reg <= ATX_PAR;
                atx_line_reg  <= atx_par_reg;
              end else begin
                atx_state_reg <= ATX_STOP;
                atx_line_reg  <= `SSP_MARK;
              end
            end else begin
              atx_line_reg <= atx_sh_reg[0];
              atx_par_reg  <= atx_par_reg ^ atx_sh_reg[0];
              atx_sh_reg   <= {1'b0, atx_sh_reg[7:1]};
            end
          end
        end
        ATX_PAR: begin
          if (atx_end) begin
            atx_state_reg <= ATX_STOP;
            atx_line_reg  <= `SSP_MARK;
          end
        end
        ATX_STOP: begin
          if (atx_end) begin
            if (atx_stop2_reg)
              atx_stop2_reg <= 1'b0;
            else
              atx_state_reg <= ATX_IDLE;
          end
        end
        default: atx_state_reg <= ATX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // asynchronous receiver, independent of the transmitter
  // ----------------------------------------------------------------
  reg  [2:0] arx_state_reg;
  reg  [3:0] arx_sub_reg;
  reg  [2:0] arx_bit_reg;
  reg  [7:0] arx_sh_reg;
  reg        arx_par_reg;
  reg        arx_perr_reg;
  reg        arx_done_reg;

  wire arx_mid = tick16 & (arx_sub_reg == `SSP_SUB_MID);
  wire arx_ctr = tick16 & (arx_sub_reg == `SSP_SUB_LAST);

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      arx_state_reg <= ARX_IDLE;
      arx_sub_reg   <= `SSP_RST_SUB;
      arx_bit_reg   <= `SSP_RST_BITS;
      arx_sh_reg    <= `SSP_RST_BYTE;
      arx_par_reg   <= 1'b0;
      arx_perr_reg  <= 1'b0;
      arx_done_reg  <= 1'b0;
    end else begin
      arx_done_reg <= 1'b0;
      if (tick16)
        arx_sub_reg <= arx_sub_reg + 4'h1;
      // disabling aborts the character but never touches the flag
      if (!rx_enable || mode_sync) begin
        arx_state_reg <= ARX_IDLE;
      end else begin
        case (arx_state_reg)
          ARX_IDLE: begin
            // new start only on a mark-to-space edge, and never while flagged
            if (!per_flag_reg && rxd_prev_reg && !rxd_f_reg) begin
              arx_state_reg <= ARX_START;
              arx_sub_reg   <= `SSP_RST_SUB;
            end
          end
          ARX_START: begin
            if (arx_mid) begin
              // glitch shorter than half a bit is dropped
              if (rxd_f_reg == `SSP_SPACE) begin
                arx_state_reg <= ARX_DATA;
                arx_sub_reg   <= `SSP_RST_SUB;
                arx_bit_reg   <= `SSP_RST_BITS;
                arx_par_reg   <= parity_odd;
              end else begin
                arx_state_reg <= ARX_IDLE;
              end
            end
          end
          ARX_DATA: begin
            if (arx_ctr) begin
              arx_sh_reg  <= {rxd_f_reg, arx_sh_reg[7:1]};
              arx_par_reg <= arx_par_reg ^ rxd_f_reg;
              arx_bit_reg <= arx_bit_reg + 3'h1;
              if (arx_bit_reg == last_bit)
                arx_state_reg <= parity_en ? ARX_PAR : ARX_STOP;
            end
          end
          ARX_PAR: begin
            if (arx_ctr) begin
              arx_perr_reg  <= arx_par_reg ^ rxd_f_reg;
              arx_state_reg <= ARX_STOP;
            end
          end
          ARX_STOP: begin
            // the stop bit is not sampled; done at the first stop bit's centre, so the next start may follow
            if (arx_ctr) begin
              if (!parity_en)
                arx_perr_reg <= 1'b0;
              arx_done_reg  <= 1'b1;
              arx_state_reg <= ARX_IDLE;
              if (data_seven)
                arx_sh_reg <= {1'b0, arx_sh_reg[7:1]};
            end
          end
          default: arx_state_reg <= ARX_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // clocked synchronous engine: one clock for both directions
  // ----------------------------------------------------------------
  reg        sy_state_reg;
  reg        sy_tx_on_reg;
  reg        sy_rx_on_reg;
  reg  [2:0] sy_bit_reg;
  reg  [7:0] sy_tsh_reg;
  reg  [7:0] sy_rsh_reg;
  reg        sy_line_reg;
  reg        sy_sck_reg;
  reg        sy_done_reg;

  wire sy_start = mode_sync & (sy_state_reg == SY_IDLE) & ~per_flag_reg &
                  ((tx_enable & ~tx_empty_reg) | (rx_enable & ~tx_enable & ~rx_full_flag_reg));
  wire sy_fall  = ext_clk ? ext_fall : (brg_tick_reg & sy_sck_reg);
  wire sy_rise  = ext_clk ? ext_rise : (brg_tick_reg & ~sy_sck_reg);

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sy_state_reg <= SY_IDLE;
      sy_tx_on_reg <= 1'b0;
      sy_rx_on_reg <= 1'b0;
      sy_bit_reg   <= `SSP_RST_BITS;
      sy_tsh_reg   <= `SSP_RST_BYTE;
      sy_rsh_reg   <= `SSP_RST_BYTE;
      sy_line_reg  <= `SSP_MARK;
      sy_sck_reg   <= `SSP_SCK_IDLE;
      sy_done_reg  <= 1'b0;
    end else begin
      sy_done_reg <= 1'b0;
      case (sy_state_reg)
        SY_IDLE: begin
          sy_sck_reg <= `SSP_SCK_IDLE;
          if (sy_start) begin
            sy_state_reg <= SY_RUN;
            sy_tx_on_reg <= tx_enable;
            sy_rx_on_reg <= rx_enable;
            sy_tsh_reg   <= tx_data_buf_reg;
            sy_bit_reg   <= `SSP_RST_BITS;
          end
        end
        SY_RUN: begin
          if (!mode_sync) begin
            sy_state_reg <= SY_IDLE;
          end else begin
            if (!ext_clk && brg_tick_reg)
              sy_sck_reg <= ~sy_sck_reg;
            if (sy_fall && sy_tx_on_reg) begin
              // line then holds this bit; after the last it holds the msb
              sy_line_reg <= sy_tsh_reg[0];
              sy_tsh_reg  <= {1'b0, sy_tsh_reg[7:1]};
            end
            if (sy_rise) begin
              if (sy_rx_on_reg)
                sy_rsh_reg <= {rxd_f_reg, sy_rsh_reg[7:1]};
              sy_bit_reg <= sy_bit_reg + 3'h1;
              if (sy_bit_reg == `SSP_SYNC_BIT_LAST) begin
                sy_state_reg <= SY_IDLE;
                sy_done_reg  <= sy_rx_on_reg;
              end
            end
          end
        end
        default: sy_state_reg <= SY_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // double buffers and parity error flag
  // ----------------------------------------------------------------
  reg        per_armed_reg;

  wire tx_take = atx_take | (sy_start & tx_enable);

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_data_buf_reg  <= `SSP_RST_BYTE;
      tx_empty_reg     <= 1'b1;
      rx_buffer_reg    <= `SSP_RST_BYTE;
      rx_full_flag_reg <= 1'b0;
      per_flag_reg     <= 1'b0;
      per_armed_reg    <= 1'b0;
    end else begin
      // a write into a full buffer is ignored
      if (tx_write && tx_empty_reg) begin
        tx_data_buf_reg <= tx_data;
        tx_empty_reg    <= 1'b0;
      end else if (tx_take) begin
        tx_empty_reg <= 1'b1;
      end
      if (per_read && per_flag_reg)
        per_armed_reg <= 1'b1;
      else if (per_write_zero)
        per_armed_reg <= 1'b0;
      // set wins over a clear in the same cycle
      if (arx_done_reg && arx_perr_reg) begin
        rx_buffer_reg <= arx_sh_reg;
        per_flag_reg  <= 1'b1;
      end else if (per_write_zero && per_armed_reg) begin
        per_flag_reg  <= 1'b0;
      end
      if ((arx_done_reg && !arx_perr_reg) || sy_done_reg) begin
        rx_buffer_reg    <= sy_done_reg ? sy_rsh_reg : arx_sh_reg;
        rx_full_flag_reg <= 1'b1;
      end else if (rx_read) begin
        rx_full_flag_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      txd_out_reg  <= `SSP_MARK;
      sck_out_reg  <= `SSP_SCK_IDLE;
      sck_oe_n_reg <= 1'b1;
    end else begin
      txd_out_reg  <= mode_sync ? sy_line_reg : atx_line_reg;
      sck_out_reg  <= sy_sck_reg;
      // drive the pin only for the internal clock in synchronous mode
      sck_oe_n_reg <= ~(mode_sync & ~ext_clk);
    end
  end

endmodule

// ### sim/ssp_checker.sv
/*
  Checker for the serial unit: concurrent assertions on its ports.
  Assumes baud_div of 1 in async runs and a sync half period under 19 clk.
*/
`timescale 1ns/100ps
module ssp_checker (
  input logic       clk,
  input logic       resetn,
  input logic       mode_sync,
  input logic       clock_source_select_hi,
  input logic [7:0] baud_div,
  input logic       tx_enable,
  input logic       tx_write,
  input logic       tx_empty_reg,
  input logic       rx_full_flag_reg,
  input logic       per_write_zero,
  input logic       per_flag_reg,
  input logic       txd_out_reg,
  input logic       sck_out_reg,
  input logic       sck_oe_n_reg
);
  logic [4:0] idle_cnt;
  logic [4:0] rise_cnt;
  logic       sck_prev;
  // ----------------------------------------
  // serial clock pulse counting
  // ----------------------------------------
  // a long high stretch marks the gap between characters
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      idle_cnt <= 5'h00;
      rise_cnt <= 5'h00;
      sck_prev <= 1'b1;
    end else begin
      sck_prev <= sck_out_reg;
      if (!sck_out_reg)
        idle_cnt <= 5'h00;
      else if (idle_cnt != 5'h1F)
        idle_cnt <= idle_cnt + 5'h01;
      if (idle_cnt == 5'h14)
        rise_cnt <= 5'h00;
      else if (sck_out_reg && !sck_prev)
        rise_cnt <= rise_cnt + 5'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  tx_taken_a: assert property (tx_write && tx_empty_reg |=> !tx_empty_reg)
    else $error("tx buffer did not take the byte");
  idle_mark_a: assert property (!mode_sync && !tx_enable |-> txd_out_reg)
    else $error("idle async line not at mark");
  sck_async_a: assert property (!mode_sync |-> sck_out_reg)
    else $error("serial clock not high outside transfers");
  sck_drive_a: assert property (mode_sync && !clock_source_select_hi
    && $past(mode_sync && !clock_source_select_hi) |-> !sck_oe_n_reg)
    else $error("internal sync clock not driven on pin");
  sck_release_a: assert property (!mode_sync || clock_source_select_hi
    |=> sck_oe_n_reg)
    else $error("serial clock pin driven with external source");
  sync_edge_a: assert property (!sck_oe_n_reg && $changed(txd_out_reg)
    |-> $fell(sck_out_reg))
    else $error("sync data changed away from falling clock");
  pulse_count_a: assert property (idle_cnt == 5'h13 |-> rise_cnt[2:0] == 3'h0)
    else $error("sync character pulse count not eight");
  per_hold_a: assert property (per_flag_reg && !per_write_zero |=> per_flag_reg)
    else $error("parity flag lost without write of zero");
  per_clear_a: assert property ($fell(per_flag_reg) |-> $past(per_write_zero))
    else $error("parity flag cleared without write");
  per_block_a: assert property (per_flag_reg && $past(per_flag_reg)
    |-> !$rose(rx_full_flag_reg) && (sck_oe_n_reg || sck_out_reg))
    else $error("transfer continued with parity flag set");
  start_len_a: assert property (!mode_sync && !clock_source_select_hi
    && baud_div == 8'h01 && $fell(txd_out_reg) |-> !txd_out_reg [*8] ##23 !txd_out_reg)
    else $error("start bit too short");
  per_cov_c: cover property ($rose(per_flag_reg));
  sync_cov_c: cover property ($fell(sck_oe_n_reg));
  async_cov_c: cover property (!mode_sync && $fell(txd_out_reg));
endmodule

bind ssp_serial_unit ssp_checker i_ssp_checker (.*);

// ### sim/ssp_remote.sv
/*
  Remote serial device: sends and decodes async frames and acts as a
  clocked sync peer. Assumes the bench sets bit and frame lengths first.
*/
`timescale 1ns/100ps
module ssp_remote (
  // settings from the bench
  input  logic        clk,
  input  logic        sync_mode,
  input  logic [7:0]  bit_len,
  input  logic [3:0]  frame_len,
  input  logic [7:0]  sync_byte,
  // serial pins
  input  logic        txd,
  input  logic        sck,
  output logic        rxd = 1'b1,
  // decoded results
  output logic [11:0] got_word = 12'h000,
  output logic [7:0]  got_cnt = 8'h00
);
  logic [11:0] w;
  logic [7:0]  sh = 8'h00;
  logic [7:0]  sd = 8'h00;
  logic [2:0]  nr = 3'h0;
  logic [2:0]  nf = 3'h0;
  int          i;
  // start bit first, data lsb first, then back to mark
  task automatic send(input logic [11:0] fw, input logic [3:0] n);
    int k;
    begin
      for (k = 0; k <= n; k++) begin
        rxd = fw[k];
        repeat (bit_len) @(negedge clk);
      end
      rxd = 1'b1;
    end
  endtask
  always begin
    @(negedge txd);
    if (!sync_mode) begin
      // bits past the last stop read as mark, as the bench notes them
      w = 12'hFFF;
      repeat (bit_len / 2) @(negedge clk);
      for (i = 0; i <= frame_len; i++) begin
        w[i] = txd;
        if (i < frame_len)
          repeat (bit_len) @(negedge clk);
      end
      got_word = w;
      got_cnt++;
    end
  end
  always @(posedge sck) if (sync_mode) begin
    sh = {txd, sh[7:1]};
    nr++;
    if (nr == 3'h0) begin
      got_word = {4'h0, sh};
      got_cnt++;
    end
  end
  always @(negedge sck) if (sync_mode) begin
    if (nf == 3'h0)
      sd = sync_byte;
    rxd = sd[nf];
    nf++;
  end
endmodule

// ### sim/testbench.sv
/*
  Self-checking bench for the serial unit with the remote device model.
  Assumes the checker is bound to the design and a 100 MHz clock.
*/
`timescale 1ns/100ps
module testbench;
  logic        clk = 1'b0, resetn = 1'b0, mode_sync = 1'b0, data_seven = 1'b0;
  logic        parity_en = 1'b0, parity_odd = 1'b0, stop_two = 1'b0, tx_write = 1'b0;
  logic        clock_source_select_hi = 1'b0, clock_source_select_lo = 1'b0;
  logic        tx_enable = 1'b1, rx_enable = 1'b1, rx_read = 1'b0;
  logic        per_read = 1'b0, per_write_zero = 1'b0, ext_on = 1'b0, sck_ext = 1'b1;
  logic [7:0]  baud_div = 8'h01, tx_data = 8'h00, bit_len = 8'h20, sync_byte = 8'h00;
  logic [7:0]  d, rd;
  logic [15:0] fr;
  logic [3:0]  flen = 4'h9;
  logic [11:0] exp_tx[$];
  logic [7:0]  exp_rx[$];
  wire         tx_empty_reg, rx_full_flag_reg, per_flag_reg, txd_out_reg;
  wire         sck_out_reg, sck_oe_n_reg, rxd_in, sck_in;
  wire  [7:0]  rx_buffer_reg;
  wire  [11:0] got_word;
  wire  [7:0]  got_cnt;
  int          seed = 30590, f, k, cycles = 0, checks_done = 0, miscompares = 0;
  assign sck_in = sck_oe_n_reg ? sck_ext : sck_out_reg;
  always #5 clk = ~clk;
  always #20 if (ext_on) sck_ext = ~sck_ext;
  ssp_serial_unit i_ssp_serial_unit (.*);
  ssp_remote i_ssp_remote (.clk(clk), .sync_mode(mode_sync), .bit_len(bit_len),
    .frame_len(flen), .sync_byte(sync_byte), .txd(txd_out_reg), .sck(sck_in),
    .rxd(rxd_in), .got_word(got_word), .got_cnt(got_cnt));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic cmp(input string nm, input logic [11:0] e, input logic [11:0] s);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  function automatic [15:0] mkframe(input [7:0] dv, input [3:0] fm, input bad);
    logic [11:0] w;
    logic [3:0]  n;
    logic [3:0]  p;
    begin
      w = 12'hFFE;
      n = fm[0] ? 4'h7 : 4'h8;
      for (int i = 0; i < n; i++) w[i + 1] = dv[i];
      p = n + 4'h1;
      if (fm[1]) begin
        w[p] = ^(fm[0] ? dv[6:0] : dv) ^ fm[2] ^ bad;
        p = p + 4'h1;
      end
      mkframe = {p + {3'h0, fm[3]}, w};
    end
  endfunction
  task write_tx(input [7:0] dv);
    for (k = 0; k < 2000 && tx_empty_reg !== 1'b1; k++) @(negedge clk);
    tx_data = dv;
    tx_write = 1'b1;
    @(negedge clk) tx_write = 1'b0;
  endtask
  task drain;
    for (k = 0; k < 6000 && exp_tx.size() + exp_rx.size() > 0; k++) @(negedge clk);
    cmp("queues_left", 12'h000, 12'(exp_tx.size() + exp_rx.size()));
    repeat (100) @(negedge clk);
  endtask
  // two bytes out back to back, one byte in at the same time
  task async_run(input [3:0] fm);
    {stop_two, parity_odd, parity_en, data_seven} = fm;
    for (int j = 0; j < 2; j++) begin
      d = $random(seed);
      fr = mkframe(d, fm, 1'b0);
      flen = fr[15:12];
      exp_tx.push_back(fr[11:0]);
      write_tx(d);
    end
    rd = $random(seed);
    fr = mkframe(rd, fm, 1'b0);
    exp_rx.push_back(fm[0] ? {1'b0, rd[6:0]} : rd);
    fork i_ssp_remote.send(fr[11:0], fr[15:12]); join_none
    @(negedge clk) tx_write = 1'b1;
    @(negedge clk) tx_write = 1'b0;
    drain;
    $display("async format %h done", fm);
  endtask
  // ----------------------------------------
  // result watchers
  // ----------------------------------------
  initial forever begin
    @(posedge rx_full_flag_reg or posedge per_flag_reg);
    @(negedge clk);
    if (exp_rx.size() == 0)
      cmp("rx_extra", 12'h000, 12'h001);
    else
      cmp("rx_buffer", {4'h0, exp_rx.pop_front()}, {4'h0, rx_buffer_reg});
    rx_read = rx_full_flag_reg;
    @(negedge clk) rx_read = 1'b0;
  end
  initial forever begin
    @(got_cnt);
    if (exp_tx.size() == 0)
      cmp("tx_extra", 12'h000, 12'h001);
    else
      cmp("tx_frame", exp_tx.pop_front(), got_word);
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      finish_test;
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    cmp("reset_flags", 12'h03C, {6'h00, txd_out_reg, sck_out_reg, sck_oe_n_reg,
      tx_empty_reg, rx_full_flag_reg, per_flag_reg});
    cmp("reset_buffer", 12'h000, {4'h0, rx_buffer_reg});
    repeat (10) @(negedge clk);
    for (f = 0; f < 16; f++) async_run(f[3:0]);
    clock_source_select_hi = 1'b1;
    ext_on = 1'b1;
    bit_len = 8'h40;
    async_run(4'h0);
    ext_on = 1'b0;
    // park the pin clock high so that sync mode sees no false edge
    sck_ext = 1'b1;
    clock_source_select_hi = 1'b0;
    bit_len = 8'h20;
    tx_enable = 1'b0;
    {stop_two, parity_odd, parity_en, data_seven} = 4'h2;
    repeat (4) @(negedge clk);
    cmp("txd_idle", 12'h001, {11'h0, txd_out_reg});
    rd = $random(seed);
    fr = mkframe(rd, 4'h2, 1'b1);
    exp_rx.push_back(rd);
    i_ssp_remote.send(fr[11:0], fr[15:12]);
    drain;
    cmp("per_set", 12'h001, {11'h0, per_flag_reg});
    cmp("rx_full_clear", 12'h000, {11'h0, rx_full_flag_reg});
    fr = mkframe(~rd, 4'h2, 1'b0);
    i_ssp_remote.send(fr[11:0], fr[15:12]);
    repeat (60) @(negedge clk);
    cmp("rx_blocked", {4'h0, rd}, {4'h0, rx_buffer_reg});
    rx_enable = 1'b0;
    per_write_zero = 1'b1;
    @(negedge clk) per_write_zero = 1'b0;
    @(negedge clk);
    cmp("per_kept", 12'h001, {11'h0, per_flag_reg});
    tx_enable = 1'b1;
    mode_sync = 1'b1;
    baud_div = 8'h07;
    d = $random(seed);
    exp_tx.push_back({4'h0, d});
    write_tx(d);
    repeat (100) @(negedge clk);
    cmp("sync_blocked", 12'h001, {11'h0, sck_out_reg});
    per_read = 1'b1;
    @(negedge clk) per_read = 1'b0;
    per_write_zero = 1'b1;
    @(negedge clk) per_write_zero = 1'b0;
    cmp("per_cleared", 12'h000, {11'h0, per_flag_reg});
    drain;
    $display("parity error test done");
    rx_enable = 1'b1;
    for (f = 0; f < 3; f++) begin
      sync_byte = $random(seed);
      d = $random(seed);
      exp_rx.push_back(sync_byte);
      exp_tx.push_back({4'h0, d});
      write_tx(d);
      for (k = 0; k < 400 && tx_empty_reg !== 1'b1; k++) @(negedge clk);
      for (k = 0; k < 40 && sck_in !== 1'b0; k++) @(negedge clk);
    end
    drain;
    cmp("msb_hold", {11'h0, d[7]}, {11'h0, txd_out_reg});
    cmp("sck_idle", 12'h001, {11'h0, sck_out_reg});
    $display("sync duplex test done");
    finish_test;
  end
endmodule
